// ==== hdl/fdci_fifo.v ====
`timescale 1ns/100ps
// The write buffer module fdci_fifo sits in fdci_top.v, beside its only user

// ==== hdl/fdci_map.vh ====
`ifndef FDCI_MAP_VH
`define FDCI_MAP_VH
`define FDCI_OFS_MON_A 3'h0
`define FDCI_OFS_MON_B 3'h1
`define FDCI_OFS_DOUT 3'h2
`define FDCI_OFS_TAPE 3'h3
`define FDCI_OFS_MSR 3'h4
`define FDCI_OFS_DATA 3'h5
`define FDCI_OFS_DIN 3'h7
`define FDCI_CMD_SPECIFY 5'h03
`define FDCI_CMD_SDS 5'h04
`define FDCI_CMD_WRITE 5'h05
`define FDCI_CMD_RECAL 5'h07
`define FDCI_CMD_SIS 5'h08
`define FDCI_CMD_WDEL 5'h09
`define FDCI_CMD_FORMAT 5'h0d
`define FDCI_CMD_DUMP 5'h0e
`define FDCI_CMD_SEEK 5'h0f
`define FDCI_CMD_VERSION 5'h10
`define FDCI_CMD_PERP 5'h12
`define FDCI_CMD_CONFIG 5'h13
`define FDCI_CMD_LOCK 5'h14
`define FDCI_CMD_VERIFY 5'h16
`define FDCI_VERSION_BYTE 8'h90
`define FDCI_INVALID_ST0 8'h80
`define FDCI_MSR_RQM 7
`define FDCI_MSR_DIO 6
`define FDCI_MSR_BUSY 3
`define FDCI_MON_INT 7
`define FDCI_MON_SECOND_DRIVE_ABSENT 6
`define FDCI_EXEC_CYCLES 8'h10
`endif

// ==== hdl/fdci_top.v ====
`timescale 1ns/100ps
`include "fdci_map.vh"
// Command interpreter and host register map of the disk controller
module fdci_top (
  input wire clk_i,
  input wire reset_i,
  input wire [2:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  input wire [1:0] compat_mode_i,
  input wire second_drive_absent_i,
  input wire [7:0] drive_pins_i,
  input wire track_zero_n_i,
  input wire write_protect_n_i,
  input wire [7:0] disk_change_i,
  output wire irq_o,
  output reg [7:0] drive_output_control_o,
  output reg [7:0] rate_select_o,
  output reg [7:0] transfer_rate_config_o,
  output reg [1:0] drive_select_o,
  output reg head_select_o,
  output reg [7:0] target_cylinder_o,
  output reg step_req_o,
  output wire [7:0] wr_data_o,
  output wire wr_valid_o,
  input wire wr_ready_i
);
  localparam S_CMD = 3'h0;
  localparam S_PARAM = 3'h1;
  localparam S_EXEC = 3'h2;
  localparam S_XFER = 3'h3;
  localparam S_RES = 3'h4;

  reg [2:0] state;
  reg [7:0] cmd;
  reg [3:0] pcount;
  reg [3:0] pneed;
  reg [3:0] ridx;
  reg [3:0] rlen;
  reg [7:0] par [0:8];
  reg [7:0] present_cylinder [0:3];
  reg [7:0] spec1, spec2, cfg, precomp_start_track, perp, last_st0;
  reg lock_bit, irq_flag;
  reg [7:0] ecnt;
  reg [7:0] tape_assign;
  reg [9:0] xfer_left;
  reg [1:0] sync_ms1, sync_ms2;
  reg sync_d1, sync_d2, sync_t1, sync_t2, sync_w1, sync_w2;
  reg [7:0] sync_p1, sync_p2, sync_c1, sync_c2;
  reg [7:0] next_res;
  wire [4:0] op;
  wire data_wr;
  wire data_rd;
  wire fifo_ready;
  wire is_write;
  wire [3:0] new_pneed;
  integer i;

  assign op = cmd[4:0];
  assign is_write = (op == `FDCI_CMD_WRITE) || (op == `FDCI_CMD_WDEL);
  // Byte moves only when the master may transfer in the right direction
  assign data_wr = wr_i && (addr_i == `FDCI_OFS_DATA) &&
                   (state == S_CMD || state == S_PARAM || (state == S_XFER && fifo_ready));
  assign data_rd = rd_i && (addr_i == `FDCI_OFS_DATA) && (state == S_RES);
  assign irq_o = irq_flag;

  // Parameter count per command byte
  function [3:0] fdci_params;
    input [7:0] c;
    begin
      case (c[4:0])
        `FDCI_CMD_VERIFY: fdci_params = 4'h8;
        `FDCI_CMD_WRITE: fdci_params = (c[5] == 1'b0) ? 4'h8 : 4'h0;
        `FDCI_CMD_WDEL: fdci_params = (c[5] == 1'b0) ? 4'h8 : 4'h0;
        `FDCI_CMD_FORMAT: fdci_params = 4'h5;
        `FDCI_CMD_RECAL: fdci_params = 4'h1;
        `FDCI_CMD_SEEK: fdci_params = c[7] ? 4'h0 : 4'h2;
        `FDCI_CMD_SPECIFY: fdci_params = 4'h2;
        `FDCI_CMD_CONFIG: fdci_params = 4'h3;
        `FDCI_CMD_PERP: fdci_params = 4'h1;
        `FDCI_CMD_SDS: fdci_params = 4'h1;
        default: fdci_params = 4'h0;
      endcase
    end
  endfunction
  assign new_pneed = fdci_params(wdata_i);

  // Write data path toward the drive, buffered so the host can run ahead
  fdci_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_wbuf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(data_wr && state == S_XFER),
    .in_ready_o(fifo_ready),
    .in_data_i(wdata_i),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(wr_data_o)
  );

  // Pin inputs pass two flip-flops before use
  always @(posedge clk_i) begin
    sync_ms1 <= compat_mode_i;
    sync_ms2 <= sync_ms1;
    sync_d1 <= second_drive_absent_i;
    sync_d2 <= sync_d1;
    sync_t1 <= track_zero_n_i;
    sync_t2 <= sync_t1;
    sync_w1 <= write_protect_n_i;
    sync_w2 <= sync_w1;
    sync_p1 <= drive_pins_i;
    sync_p2 <= sync_p1;
    sync_c1 <= disk_change_i;
    sync_c2 <= sync_c1;
  end

  // Result byte selection by command and index
  always @* begin
    next_res = 8'h00;
    case (op)
      `FDCI_CMD_VERSION: next_res = `FDCI_VERSION_BYTE;
      `FDCI_CMD_SIS: next_res = (ridx == 4'h0) ? last_st0 : present_cylinder[drive_select_o];
      `FDCI_CMD_SDS: next_res = {1'b0, ~sync_w2, 1'b1, ~sync_t2, 1'b1, head_select_o,
                                 drive_select_o};
      `FDCI_CMD_LOCK: next_res = {3'h0, lock_bit, 4'h0};
      `FDCI_CMD_DUMP: begin
        case (ridx)
          4'h0: next_res = present_cylinder[0];
          4'h1: next_res = present_cylinder[1];
          4'h2: next_res = present_cylinder[2];
          4'h3: next_res = present_cylinder[3];
          4'h4: next_res = spec1;
          4'h5: next_res = spec2;
          4'h6: next_res = par[5];
          4'h7: next_res = {lock_bit, 1'b0, perp[5:0]};
          4'h8: next_res = cfg;
          4'h9: next_res = precomp_start_track;
          default: next_res = 8'h00;
        endcase
      end
      `FDCI_CMD_VERIFY, `FDCI_CMD_WRITE, `FDCI_CMD_WDEL, `FDCI_CMD_FORMAT: begin
        case (ridx)
          4'h0: next_res = last_st0;
          4'h1: next_res = 8'h00;
          4'h2: next_res = 8'h00;
          4'h3: next_res = par[1];
          4'h4: next_res = par[2];
          4'h5: next_res = par[3];
          4'h6: next_res = par[4];
          default: next_res = 8'h00;
        endcase
      end
      default: next_res = `FDCI_INVALID_ST0;
    endcase
  end

  // Command phase sequencing
  always @(posedge clk_i) begin
    if (reset_i) begin
      state <= S_CMD;
      cmd <= 8'h00;
      pcount <= 4'h0;
      pneed <= 4'h0;
      ridx <= 4'h0;
      rlen <= 4'h0;
      for (i = 0; i < 9; i = i + 1) par[i] <= 8'h00;
      for (i = 0; i < 4; i = i + 1) present_cylinder[i] <= 8'h00;
      spec1 <= 8'h00;
      spec2 <= 8'h00;
      cfg <= 8'h00;
      precomp_start_track <= 8'h00;
      perp <= 8'h00;
      last_st0 <= 8'h00;
      lock_bit <= 1'b0;
      irq_flag <= 1'b0;
      ecnt <= 8'h00;
      xfer_left <= 10'h000;
      drive_select_o <= 2'h0;
      head_select_o <= 1'b0;
      target_cylinder_o <= 8'h00;
      step_req_o <= 1'b0;
    end else begin
      step_req_o <= 1'b0;
      case (state)
        S_CMD: begin
          if (data_wr) begin
            cmd <= wdata_i;
            pcount <= 4'h0;
            pneed <= new_pneed;
            ridx <= 4'h0;
            if (new_pneed != 4'h0) state <= S_PARAM;
            else begin
              state <= S_EXEC;
              ecnt <= `FDCI_EXEC_CYCLES;
            end
          end
        end
        S_PARAM: begin
          if (data_wr) begin
            par[pcount] <= wdata_i;
            pcount <= pcount + 4'h1;
            // Only commands whose first parameter is a head/drive byte move the selection
            if (pcount == 4'h0 && op != `FDCI_CMD_SPECIFY && op != `FDCI_CMD_CONFIG &&
                op != `FDCI_CMD_PERP) begin
              drive_select_o <= wdata_i[1:0];
              head_select_o <= wdata_i[2];
            end
            if (pcount + 4'h1 == pneed) begin
              state <= S_EXEC;
              ecnt <= `FDCI_EXEC_CYCLES;
            end
          end
        end
        S_EXEC: begin
          ecnt <= ecnt - 8'h01;
          if (ecnt == `FDCI_EXEC_CYCLES) begin
            // Capture settings and start motion once
            case (op)
              `FDCI_CMD_SPECIFY: begin
                spec1 <= par[0];
                spec2 <= par[1];
              end
              `FDCI_CMD_CONFIG: begin
                cfg <= {1'b0, par[1][6:0]};
                precomp_start_track <= par[2];
              end
              `FDCI_CMD_PERP: perp <= par[0];
              `FDCI_CMD_LOCK: lock_bit <= cmd[7];
              `FDCI_CMD_RECAL: begin
                target_cylinder_o <= 8'h00;
                step_req_o <= 1'b1;
              end
              `FDCI_CMD_SEEK: begin
                target_cylinder_o <= par[1];
                step_req_o <= 1'b1;
              end
              default: ;
            endcase
            if (op == `FDCI_CMD_SIS) irq_flag <= 1'b0;
          end
          if (ecnt == 8'h01) begin
            ridx <= 4'h0;
            case (op)
              `FDCI_CMD_RECAL, `FDCI_CMD_SEEK: begin
                present_cylinder[drive_select_o] <= target_cylinder_o;
                last_st0 <= {2'b00, 1'b1, 2'b00, head_select_o, drive_select_o};
                irq_flag <= 1'b1;
                state <= S_CMD;
              end
              `FDCI_CMD_SPECIFY, `FDCI_CMD_CONFIG, `FDCI_CMD_PERP: state <= S_CMD;
              `FDCI_CMD_VERIFY: begin
                last_st0 <= {5'h00, head_select_o, drive_select_o};
                rlen <= 4'h7;
                state <= S_RES;
              end
              `FDCI_CMD_WRITE, `FDCI_CMD_WDEL, `FDCI_CMD_FORMAT: begin
                last_st0 <= {5'h00, head_select_o, drive_select_o};
                // Four ID bytes per sector on format; a fixed 128-byte sector otherwise
                xfer_left <= is_write ? 10'h080 : {par[2], 2'b00};
                if (!is_write && par[2] == 8'h00) begin
                  rlen <= 4'h6; // An empty track takes no ID bytes
                  state <= S_RES;
                end else state <= S_XFER;
              end
              `FDCI_CMD_SIS: begin
                rlen <= 4'h2;
                state <= S_RES;
              end
              `FDCI_CMD_DUMP: begin
                rlen <= 4'ha;
                state <= S_RES;
              end
              `FDCI_CMD_VERSION, `FDCI_CMD_LOCK, `FDCI_CMD_SDS: begin
                rlen <= 4'h1;
                state <= S_RES;
              end
              default: begin
                rlen <= 4'h1;
                state <= S_RES;
              end
            endcase
          end
        end
        S_XFER: begin
          // Each accepted host byte counts down the transfer
          if (data_wr) begin
            xfer_left <= xfer_left - 10'h001;
            if (xfer_left == 10'h001) begin
              rlen <= is_write ? 4'h7 : 4'h6;
              state <= S_RES;
            end
          end
        end
        S_RES: begin
          if (data_rd) begin
            ridx <= ridx + 4'h1;
            if (ridx + 4'h1 == rlen) state <= S_CMD;
          end
        end
        default: state <= S_CMD;
      endcase
    end
  end

  // Host-written control registers
  always @(posedge clk_i) begin
    if (reset_i) begin
      drive_output_control_o <= 8'h00;
      rate_select_o <= 8'h00;
      transfer_rate_config_o <= 8'h00;
      tape_assign <= 8'h00;
    end else if (wr_i) begin
      case (addr_i)
        `FDCI_OFS_DOUT: drive_output_control_o <= wdata_i;
        `FDCI_OFS_TAPE: tape_assign <= {6'h00, wdata_i[1:0]};
        `FDCI_OFS_MSR: rate_select_o <= wdata_i;
        `FDCI_OFS_DIN: transfer_rate_config_o <= wdata_i;
        default: ;
      endcase
    end
  end

  // Read data mux, registered
  always @(posedge clk_i) begin
    if (reset_i) rdata_o <= 8'h00;
    else if (rd_i) begin
      case (addr_i)
        `FDCI_OFS_MON_A: begin
          if (sync_ms2 == 2'b00) rdata_o <= 8'h00;
          else begin
            rdata_o <= sync_p2;
            rdata_o[`FDCI_MON_INT] <= irq_flag;
            if (sync_ms2 == 2'b01) rdata_o[`FDCI_MON_SECOND_DRIVE_ABSENT] <= sync_d2;
          end
        end
        `FDCI_OFS_MON_B: rdata_o <= (sync_ms2 == 2'b00) ? 8'h00 :
                                    {sync_d2, 4'h0, drive_output_control_o[0], 2'h0};
        `FDCI_OFS_TAPE: rdata_o <= tape_assign;
        `FDCI_OFS_MSR: rdata_o <= {(state == S_CMD || state == S_PARAM || state == S_RES ||
                                    (state == S_XFER && fifo_ready)),
                                   (state == S_RES), 2'b00,
                                   (state != S_CMD), 3'h0};
        `FDCI_OFS_DATA: rdata_o <= (state == S_RES) ? next_res : 8'h00;
        `FDCI_OFS_DIN: rdata_o <= sync_c2;
        default: rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // fdci_top

// Small synchronous FIFO with valid/ready on both sides
module fdci_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_i,
  input wire reset_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  // Occupancy decides both flags, so full and empty never disagree with the pointers
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  // Pointers and occupancy
  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push & ~pop) count <= count + 1'b1;
      else if (pop & ~push) count <= count - 1'b1;
    end
  end
endmodule // fdci_fifo

// ==== verif/fdci_chk.sv ====
`timescale 1ns/100ps
// Port checks of the command interpreter
module fdci_chk (
  input wire clk_i,
  input wire reset_i,
  input wire [2:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire [1:0] compat_mode_i,
  input wire second_drive_absent_i,
  input wire irq_o,
  input wire [7:0] drive_output_control_o,
  input wire [7:0] rate_select_o,
  input wire [7:0] transfer_rate_config_o,
  input wire step_req_o,
  input wire [7:0] wr_data_o,
  input wire wr_valid_o,
  input wire wr_ready_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  mon_normal_a: assert property (rd_i && addr_i == 3'h0 && $past(compat_mode_i, 2) == 2'h0 |=>
    rdata_o == 8'h00) else $error("monitor not zero in normal mode");
  mon_irq_a: assert property (rd_i && addr_i == 3'h0 && $past(compat_mode_i, 2) != 2'h0 |=>
    rdata_o[7] == $past(irq_o)) else $error("monitor bit 7 differs from irq");
  mon_drive2_a: assert property (rd_i && addr_i == 3'h0 && $past(compat_mode_i, 2) == 2'h1 |=>
    rdata_o[6] == $past(second_drive_absent_i, 3)) else $error("second drive bit wrong");
  hole_read_a: assert property (rd_i && addr_i == 3'h6 |=> rdata_o == 8'h00)
    else $error("unmapped offset not zero");
  dout_write_a: assert property (wr_i && addr_i == 3'h2 |=>
    drive_output_control_o == $past(wdata_i)) else $error("offset 2 write lost");
  rate_write_a: assert property (wr_i && addr_i == 3'h4 |=>
    rate_select_o == $past(wdata_i)) else $error("offset 4 write lost");
  ccr_write_a: assert property (wr_i && addr_i == 3'h7 |=>
    transfer_rate_config_o == $past(wdata_i)) else $error("offset 7 write lost");
  step_irq_a: assert property (step_req_o |=> !step_req_o ##[0:200] irq_o)
    else $error("step without end interrupt");
  fifo_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o &&
    $stable(wr_data_o)) else $error("write data dropped while stalled");
endmodule // fdci_chk

bind fdci_top fdci_chk u_fdci_chk (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .compat_mode_i(compat_mode_i),
  .second_drive_absent_i(second_drive_absent_i), .irq_o(irq_o),
  .drive_output_control_o(drive_output_control_o), .rate_select_o(rate_select_o),
  .transfer_rate_config_o(transfer_rate_config_o), .step_req_o(step_req_o),
  .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i)
);

// ==== verif/fdci_drive_model.sv ====
`timescale 1ns/100ps
// Drive-side sink; stalls at random so the write FIFO really fills
module fdci_drive_model (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] data_i,
  input wire valid_i,
  output logic ready_o = 1'b0,
  output logic [15:0] count_o,
  output logic [15:0] sum_o
);
  // Count and sum every byte taken on a valid-and-ready edge
  always @(posedge clk_i) begin
    ready_o <= !reset_i && ($urandom % 3 == 0);
    if (reset_i) begin
      count_o <= 16'h0;
      sum_o <= 16'h0;
    end else if (valid_i && ready_o) begin
      count_o <= count_o + 16'h1;
      sum_o <= sum_o + {8'h0, data_i};
    end
  end
endmodule // fdci_drive_model

// ==== verif/test_fdci_top.sv ====
`timescale 1ns/100ps
module test_fdci_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [7:0] wdata_i = 8'h0;
  logic [1:0] compat_mode_i = 2'h0;
  logic second_absent = 1'b0;
  logic [7:0] pins = 8'h0;
  wire [7:0] rdata_o, wr_data_o, target_cylinder_o;
  wire irq_o, wr_valid_o, wr_ready;
  wire [1:0] dsel;
  wire hsel;
  wire [15:0] count, sum;
  logic [7:0] last, c;
  logic [7:0] p[0:6];
  logic [7:0] cq[$];
  logic [8:0] rq[$];
  logic [15:0] eq[$];
  logic rc = 1'b0;
  logic pend = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int i, k;

  fdci_top u_fdci_top (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .compat_mode_i(compat_mode_i),
    .second_drive_absent_i(second_absent), .drive_pins_i(pins), .track_zero_n_i(pins[0]),
    .write_protect_n_i(pins[1]), .disk_change_i(~pins), .irq_o(irq_o),
    .drive_output_control_o(), .rate_select_o(), .transfer_rate_config_o(),
    .drive_select_o(dsel), .head_select_o(hsel), .target_cylinder_o(target_cylinder_o),
    .step_req_o(), .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready)
  );
  fdci_drive_model u_fdci_drive_model (.clk_i(clk_i), .reset_i(reset_i),
    .data_i(wr_data_o), .valid_i(wr_valid_o), .ready_o(wr_ready), .count_o(count),
    .sum_o(sum));

  always #50 clk_i = ~clk_i;

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One access held over one rising edge, then a quiet cycle so strobes never re-arm at once
  task acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic ck);
    addr_i = a;
    wdata_i = d;
    wr_i = w;
    rd_i = !w;
    rc = ck;
    @(negedge clk_i);
    last = rdata_o;
    wr_i = 1'b0;
    rd_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Poll the handshake status until the port is ready in the wanted direction
  task poll(input logic transfer_direction);
    int n;
    for (n = 0; n < 3000; n++) begin
      acc(1'b0, 3'h4, 8'h0, 1'b0);
      if (last[7] === 1'b1 && last[6] === transfer_direction) return;
    end
    fail_count++;
    $display("CHECK FAILED %0t: handshake timeout", $time);
    end_sim();
  endtask

  // Send the byte list, then read results; bit 8 set marks a byte of no fixed value
  task txn();
    foreach (cq[j]) begin
      poll(1'b0);
      acc(1'b1, 3'h5, cq[j], 1'b0);
    end
    foreach (rq[j]) begin
      poll(1'b1);
      if (!rq[j][8]) eq.push_back({8'h0, rq[j][7:0]});
      acc(1'b0, 3'h5, 8'h0, !rq[j][8]);
    end
    poll(1'b0);
  endtask

  task wirq();
    for (k = 0; k < 500 && irq_o !== 1'b1; k++) @(negedge clk_i);
    chk({15'h0, irq_o}, 16'h1);
  endtask

  // Let the sink empty the write buffer before its totals are compared
  task drain();
    for (k = 0; k < 300 && wr_valid_o !== 1'b0; k++) @(negedge clk_i);
    chk({15'h0, wr_valid_o}, 16'h0);
  endtask

  // Result watcher: a marked read takes the oldest note when its data appears
  always @(posedge clk_i) pend <= rd_i && rc;
  always @(negedge clk_i) if (pend) chk({8'h0, rdata_o}, eq.pop_front());

  initial begin
    void'($urandom(32'h83d5));
    pins = $urandom;
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    // Plain registers, unmapped offset and the pin monitor
    acc(1'b1, 3'h2, $urandom, 1'b0);
    acc(1'b1, 3'h4, $urandom, 1'b0);
    acc(1'b1, 3'h7, $urandom, 1'b0);
    c = $urandom;
    acc(1'b1, 3'h3, c, 1'b0);
    eq.push_back({14'h0, c[1:0]}); // Only the drive-number bits are kept
    acc(1'b0, 3'h3, 8'h0, 1'b1);
    acc(1'b0, 3'h0, 8'h0, 1'b0);
    acc(1'b0, 3'h6, 8'h0, 1'b0);
    compat_mode_i = 2'h1;
    second_absent = 1'b1;
    repeat (4) @(negedge clk_i);
    acc(1'b0, 3'h0, 8'h0, 1'b0);
    chk({15'h0, last[7]}, 16'h0);
    chk({15'h0, last[6]}, 16'h1);
    // Single-byte commands: version, unknown code, lock on and off
    for (i = 0; i < 4; i++) begin
      cq = '{i == 0 ? 8'h10 : i == 1 ? 8'h01 : i == 2 ? 8'h94 : 8'h14};
      rq = '{i == 0 ? 9'h090 : i == 1 ? 9'h080 : i == 2 ? 9'h010 : 9'h000};
      txn();
    end
    // Seek then recalibrate, each closed by a sense of the interrupt
    c = $urandom;
    rq = {};
    cq = '{8'h0f, 8'h05, c};
    txn();
    wirq();
    chk({8'h0, target_cylinder_o}, {8'h0, c});
    chk({13'h0, hsel, dsel}, 16'h5);
    acc(1'b0, 3'h0, 8'h0, 1'b0);
    chk({15'h0, last[7]}, 16'h1);
    cq = '{8'h08};
    rq = '{9'h025, {1'b0, c}};
    txn();
    chk({15'h0, irq_o}, 16'h0);
    cq = '{8'h07, 8'h01};
    rq = {};
    txn();
    wirq();
    cq = '{8'h08};
    rq = '{9'h021, 9'h000};
    txn();
    // Configuration commands read back through the register dump, then a sense of drive status
    for (k = 0; k < 7; k++) p[k] = $urandom;
    p[0][7] = 1'b0;
    p[3][0] = 1'b1;
    cq = '{8'h13, 8'h00, p[0], p[1], 8'h03, p[2], p[3], 8'h12, p[4], 8'h0e};
    rq = '{9'h0, 9'h0, 9'h0, 9'h0, {1'b0, p[2]}, {1'b0, p[3]}, 9'h100,
      {3'h0, p[4][5:0]}, {1'b0, p[0]}, {1'b0, p[1]}};
    txn();
    cq = '{8'h04, 8'h06};
    rq = '{{2'b00, ~pins[1], 1'b1, ~pins[0], 4'b1110}};
    txn();
    // Write, write deleted and verify; the sink stalls meanwhile
    for (i = 0; i < 3; i++) begin
      for (k = 0; k < 7; k++) p[k] = $urandom;
      cq = '{i == 0 ? 8'hc5 : i == 1 ? 8'h49 : 8'h16, 8'h02, p[0], p[1], p[2], p[3], p[4],
        p[5], p[6]};
      if (i < 2) for (k = 0; k < 128; k++) cq.push_back(k[7:0]);
      rq = '{9'h002, 9'h0, 9'h0, {1'b0, p[0]}, {1'b0, p[1]}, {1'b0, p[2]}, {1'b0, p[3]}};
      txn();
      drain();
      chk(count, i == 0 ? 16'd128 : 16'd256);
      chk(sum, i == 0 ? 16'd8128 : 16'd16256);
    end
    // Format two sectors: IDs follow the parameters
    cq = '{8'h4d, 8'h00, 8'h02, 8'h02, 8'h1b, 8'he5, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00,
      8'h00, 8'h02, 8'h02};
    rq = '{9'h0, 9'h0, 9'h0, 9'h100, 9'h100, 9'h100};
    txn();
    drain();
    chk(count, 16'd264);
    chk(sum, 16'd16263);
    end_sim();
  end
endmodule // test_fdci_top
